// >>> logic/key_scan_port_registers.sv
// Purpose: key-scan, key input and sense pin port registers behind AXI4-Lite
// Assumes: pins asynchronous, synced by two flops; pull-down enables are outputs
// Notes: output enables are active low; retention level from supply detector
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module key_scan_port_registers
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] key_scan_pins_in,
    output logic [7:0] key_scan_pins_out,
    output logic [7:0] key_scan_pins_oe_n,
    output logic key_scan_pulldown,
    input wire logic [3:0] key_input_pins,
    output logic key_input_pulldown,
    input wire logic first_sense_pin,
    output logic first_sense_enable,
    output logic first_sense_pulldown,
    input wire logic indicator_sense_pin_in,
    output logic indicator_sense_pin_out,
    output logic indicator_sense_pin_oe_n,
    output logic indicator_sense_pulldown,
    input wire logic indicator_drive,
    input wire logic wake_sense_pin,
    output logic wake_sense_pulldown,
    input wire logic release_condition,
    output logic stop_release,
    input wire logic retention_detect_level
);
    port_pkg::state_t s;
    port_pkg::state_t next_s;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic do_write;
    logic [7:0] wbyte;
    logic [7:0] read_byte;
    logic read_hit;
    logic write_hit;
    logic [7:0] sense_word;
    logic ar_scan;
    logic ar_sense;
    logic ar_miss;
    logic pm_write;

    // Address and data are taken independently, only when no response is pending
    assign s_axi_awready = !s.aw_seen && !s.bvalid;
    assign s_axi_wready = !s.w_seen && !s.bvalid;
    assign s_axi_arready = !s.rvalid;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign do_write = s.aw_seen && s.w_seen && !s.bvalid;
    assign wbyte = s.w_data[7:0];

    // Input port image; gated first sense reads 1, bit 0 fixed to 1
    assign sense_word = {s.key_sync,
                         s.sense_sync[1],
                         s.pin_mode[port_pkg::PM_FIRST_SENSE_IN] ? s.sense_sync[0] : 1'b1,
                         s.sense_sync[2],
                         1'b1};

    // Read mux, selected by register number in one cycle
    always_comb
    begin
        read_hit = 1'b1;
        case (s_axi_araddr[3:0])
            port_pkg::ADDR_KEY_SCAN: read_byte = s.pin_mode[port_pkg::PM_KEY_SCAN_OUT] ?
                                                 s.scan_latch : s.scan_sync;
            port_pkg::ADDR_KEY_SENSE: read_byte = sense_word;
            port_pkg::ADDR_PTR_CTRL: read_byte = s.ptr_ctrl;
            port_pkg::ADDR_PIN_MODE: read_byte = s.pin_mode;
            default:
            begin
                read_byte = 8'h00;
                read_hit = 1'b0;
            end
        endcase
        if (s_axi_araddr[31:4] != 28'h0000000)
        begin
            read_hit = 1'b0;
            read_byte = 8'h00;
        end
    end

    assign write_hit = (s.aw_addr == port_pkg::ADDR_KEY_SCAN) || (s.aw_addr == port_pkg::ADDR_KEY_SENSE) ||
                       (s.aw_addr == port_pkg::ADDR_PTR_CTRL) || (s.aw_addr == port_pkg::ADDR_PIN_MODE);

    // Next-state logic for every register of the block
    always_comb
    begin
        next_s = s;
        next_s.scan_meta = key_scan_pins_in;
        next_s.scan_sync = s.scan_meta;
        next_s.key_meta = key_input_pins;
        next_s.key_sync = s.key_meta;
        // First sense pin gated while off so a floating pin causes no activity
        next_s.sense_meta = {wake_sense_pin, indicator_sense_pin_in,
                             first_sense_pin && s.pin_mode[port_pkg::PM_FIRST_SENSE_IN]};
        next_s.sense_sync = s.sense_meta;
        next_s.stop_release = release_condition && s.pin_mode[port_pkg::PM_WAKE_EN];
        if (aw_take)
        begin
            next_s.aw_seen = 1'b1;
            next_s.aw_addr = (s_axi_awaddr[31:4] == 28'h0000000) ? s_axi_awaddr[3:0] : 4'h1;
        end
        if (w_take)
        begin
            next_s.w_seen = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (do_write)
        begin
            next_s.aw_seen = 1'b0;
            next_s.w_seen = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = write_hit ? port_pkg::RESP_OKAY : port_pkg::RESP_SLVERR;
            if (s.w_strb[0])
            begin
                case (s.aw_addr)
                    port_pkg::ADDR_KEY_SCAN: next_s.scan_latch = wbyte;
                    port_pkg::ADDR_PTR_CTRL: next_s.ptr_ctrl = wbyte & port_pkg::PTR_CTRL_MASK;
                    port_pkg::ADDR_PIN_MODE: next_s.pin_mode = wbyte & port_pkg::PIN_MODE_MASK;
                    default: next_s.bresp = next_s.bresp;                 // Input port ignores writes
                endcase
            end
        end
        if (s.bvalid && s_axi_bready)
        begin
            next_s.bvalid = 1'b0;
        end
        if (ar_take)
        begin
            next_s.rvalid = 1'b1;
            next_s.rdata = {24'h000000, read_byte};
            next_s.rresp = read_hit ? port_pkg::RESP_OKAY : port_pkg::RESP_SLVERR;
        end
        else if (s.rvalid && s_axi_rready)
        begin
            next_s.rvalid = 1'b0;
        end
        // Supply dip clears retention; it wins over a software set in the same cycle
        if (retention_detect_level)
        begin
            next_s.ptr_ctrl[port_pkg::PC_RETAIN] = 1'b0;
        end
    end

    // Registered state; retention flag survives reset unless supply dipped
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
            s.scan_latch <= port_pkg::KEY_SCAN_RESET;
            s.pin_mode <= port_pkg::PIN_MODE_RESET;
            s.ptr_ctrl[port_pkg::PC_RETAIN] <= s.ptr_ctrl[port_pkg::PC_RETAIN] &&
                                              !retention_detect_level;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Pin drivers and pull-downs follow pin-mode; pull-downs off in output/off mode
    assign key_scan_pins_out = s.scan_latch;
    assign key_scan_pins_oe_n = {8{!s.pin_mode[port_pkg::PM_KEY_SCAN_OUT]}};
    assign key_scan_pulldown = !s.pin_mode[port_pkg::PM_KEY_SCAN_OUT];
    assign key_input_pulldown = s.pin_mode[port_pkg::PM_KEY_IN_PD];
    assign first_sense_enable = s.pin_mode[port_pkg::PM_FIRST_SENSE_IN];
    assign first_sense_pulldown = s.pin_mode[port_pkg::PM_SENSE_PD] &&
                                  s.pin_mode[port_pkg::PM_FIRST_SENSE_IN];
    assign indicator_sense_pin_out = indicator_drive;
    assign indicator_sense_pin_oe_n = !s.pin_mode[port_pkg::PM_INDICATOR_OUT];
    assign indicator_sense_pulldown = s.pin_mode[port_pkg::PM_SENSE_PD] &&
                                      !s.pin_mode[port_pkg::PM_INDICATOR_OUT];
    assign wake_sense_pulldown = s.pin_mode[port_pkg::PM_WAKE_EN];
    assign stop_release = s.stop_release;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;

    // Checks next to the logic they guard. Bus timing they rely on:
    // an address is taken when valid and ready meet, the read answer
    // stands one edge later, and a write answers one edge after both
    // halves are held. Responses stand until the master takes them, so
    // a slow master only stretches a transfer and never loses one.
    // Pin reads lag the pins by the two synchroniser stages, so read
    // checks compare against the synced copies, not the raw pins.

    // Decodes for the checks only; full address so aliases are excluded
    assign ar_scan = ar_take && s_axi_araddr == {28'h0000000, port_pkg::ADDR_KEY_SCAN};
    assign ar_sense = ar_take && s_axi_araddr == {28'h0000000, port_pkg::ADDR_KEY_SENSE};
    assign ar_miss = ar_take && !read_hit;
    assign pm_write = do_write && s.aw_addr == port_pkg::ADDR_PIN_MODE && s.w_strb[0];

    // A byte lands in the key-scan latch at this edge
    sequence scan_write_s;
        do_write && s.aw_addr == port_pkg::ADDR_KEY_SCAN && s.w_strb[0];
    endsequence

    // A byte lands in the pin-mode register at this edge
    sequence pin_mode_write_s;
        pm_write;
    endsequence

    // Input-mode read of the key-scan port
    sequence scan_live_read_s;
        ar_scan && !s.pin_mode[port_pkg::PM_KEY_SCAN_OUT];
    endsequence

    // Read of the key and sense input port
    sequence sense_read_s;
        ar_sense;
    endsequence

    // Read of an address outside the map
    sequence miss_read_s;
        ar_miss;
    endsequence

    // Write aimed at the read-only input port
    sequence input_write_s;
        do_write && s.aw_addr == port_pkg::ADDR_KEY_SENSE;
    endsequence

    // Both halves of a write held, no response pending
    sequence write_pair_s;
        s.aw_seen && s.w_seen && !s.bvalid;
    endsequence

    // Written byte shows on the latch next cycle
    AST_SCAN_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
        scan_write_s |=> key_scan_pins_out == $past(wbyte))
        else $error("latch not loaded");

    // Latch moves only through a key-scan write
    AST_LATCH_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        !(do_write && s.aw_addr == port_pkg::ADDR_KEY_SCAN && s.w_strb[0]) |=> $stable(s.scan_latch))
        else $error("latch moved without write");

    // Direction and pull-down follow the written mode bit
    AST_SCAN_DIR: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_mode_write_s |=> key_scan_pins_oe_n == {8{!$past(wbyte[port_pkg::PM_KEY_SCAN_OUT])}} && key_scan_pulldown == !$past(wbyte[port_pkg::PM_KEY_SCAN_OUT]))
        else $error("scan direction wrong");

    // Input-mode read returns the synced pin levels
    AST_SCAN_LIVE: assert property (@(posedge aclk) disable iff (!aresetn)
        scan_live_read_s |=> s_axi_rdata[7:0] == $past(s.scan_sync))
        else $error("scan read not live");

    // Reset loads pin modes and an all-ones latch
    AST_RESET_MODE: assert property (@(posedge aclk)
        !aresetn |=> s.pin_mode == port_pkg::PIN_MODE_RESET && s.scan_latch == port_pkg::KEY_SCAN_RESET)
        else $error("bad reset");

    // No pull-down while a pin drives or is off
    AST_PD_EXCL: assert property (@(posedge aclk) disable iff (!aresetn)
        !(key_scan_pulldown && !key_scan_pins_oe_n[0]) && !(indicator_sense_pulldown && !indicator_sense_pin_oe_n)
        && !(first_sense_pulldown && !first_sense_enable))
        else $error("pull-down in output");

    // Off first sense pin reads as one
    AST_SENSE_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_sense && !s.pin_mode[port_pkg::PM_FIRST_SENSE_IN] |=> s_axi_rdata[2])
        else $error("off sense not 1");

    // Key inputs read live in the top nibble
    AST_KEY_READ: assert property (@(posedge aclk) disable iff (!aresetn)
        sense_read_s |=> s_axi_rdata[7:4] == $past(s.key_sync))
        else $error("key input read wrong");

    // Wake pin reads live, bit zero fixed to one
    AST_WAKE_READ: assert property (@(posedge aclk) disable iff (!aresetn)
        sense_read_s |=> s_axi_rdata[1] == $past(s.sense_sync[2]) && s_axi_rdata[0])
        else $error("wake read wrong");

    // Indicator pin reads live in either mode
    AST_IND_READ: assert property (@(posedge aclk) disable iff (!aresetn)
        sense_read_s |=> s_axi_rdata[3] == $past(s.sense_sync[1]))
        else $error("indicator read wrong");

    // Writes to the input port leave the latch and pin modes unchanged
    AST_INPUT_RO: assert property (@(posedge aclk) disable iff (!aresetn)
        input_write_s |=> $stable(s.scan_latch) && $stable(s.pin_mode))
        else $error("input port write had effect");

    // Stop release needs the enable and the condition
    AST_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_release |-> $past(s.pin_mode[port_pkg::PM_WAKE_EN]) && $past(release_condition))
        else $error("bad wake");

    // Wake pull-down follows the release enable
    AST_WAKE_PD: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_mode_write_s |=> wake_sense_pulldown == $past(wbyte[port_pkg::PM_WAKE_EN]))
        else $error("wake pull-down wrong");

    // Sense pull-down only with its bit and input mode
    AST_SENSE_PD: assert property (@(posedge aclk) disable iff (!aresetn)
        first_sense_pulldown |-> s.pin_mode[port_pkg::PM_SENSE_PD] && first_sense_enable)
        else $error("sense pull-down");

    // First sense mode follows the written bit
    AST_FIRST_MODE: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_mode_write_s |=> first_sense_enable == $past(wbyte[port_pkg::PM_FIRST_SENSE_IN]))
        else $error("first sense mode wrong");

    // Key input pull-down follows its bit
    AST_KEY_PD: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_mode_write_s |=> key_input_pulldown == $past(wbyte[port_pkg::PM_KEY_IN_PD]))
        else $error("key pull-down wrong");

    // Driving indicator carries the timer level, no pull-down
    AST_IND_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
        !indicator_sense_pin_oe_n |-> indicator_sense_pin_out == indicator_drive && !indicator_sense_pulldown)
        else $error("indicator output wrong");

    // Fixed-zero bits stay zero
    AST_MODE_TOP: assert property (@(posedge aclk) disable iff (!aresetn)
        s.pin_mode[7:6] == 2'h0 && !s.ptr_ctrl[2])
        else $error("fixed bit set");

    // Pin modes move only through a pin-mode write
    AST_PIN_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        !pm_write |=> $stable(s.pin_mode))
        else $error("pin mode moved");

    // Supply dip clears retention, in or out of reset
    AST_RETAIN: assert property (@(posedge aclk)
        retention_detect_level |=> !s.ptr_ctrl[port_pkg::PC_RETAIN])
        else $error("retention not cleared");

    // Read answered the next cycle, upper bits zero
    AST_READ_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
        else $error("read slow");

    // Write answered the cycle after both halves are held
    AST_WRITE_RESP: assert property (@(posedge aclk) disable iff (!aresetn)
        write_pair_s |=> s_axi_bvalid)
        else $error("write slow");

    // Write response stands until taken
    AST_B_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");

    // Read response stands until taken
    AST_R_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response dropped");

    // Unmapped read gives an error and zero data
    AST_MISS: assert property (@(posedge aclk) disable iff (!aresetn)
        miss_read_s |=> s_axi_rresp == port_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read wrong");
endmodule

// >>> logic/port_pkg.sv
// Purpose: constants and carriers for the key-scan port register block
// Assumes: AXI4-Lite register access, 25 MHz core clock, one 32-bit word per register
// Notes: register offsets are byte addresses
//
// How it works
// - key-scan read gives pin levels in input mode, latch in output mode
// - key-scan write always loads the eight-bit output latch
// - pin-mode bit 1 sets all key-scan pins: 0 input, 1 output
// - after reset key-scan port outputs with latch all ones
// - key-scan pull-down only while the port is in input mode
// - pin-mode bit 5 sets key input pull-downs; key inputs read live
// - key input pull-down connected after reset
// - input port bits 7..4 read key inputs; writes ignored
// - input port bit 1 reads the wake sense pin live
// - pin-mode bit 0 puts first sense pin in input (1) or off (0)
// - first sense pin off reads 1 and its input path is gated
// - first sense pin off, undriven, no pull-down after reset
// - pin-mode bit 4 sets both sense pull-downs, input mode only
// - pin-mode bit 2 sets indicator pin mode; bit 3 reads it live
// - indicator output mode drops pull-down and drives timer indicator
// - indicator pin outputs high after reset
// - stop-release enable on: wake pin pull-down on, may end stop
// - stop-release enable off: plain input, no pull-down, never ends stop
// - wake pin after reset: input, release disabled, no pull-down
// - reset clears control register zero except retention flag
// - pin-mode register resets to 0x26
// - every pull-down off in output or off mode
package port_pkg;
    localparam logic [3:0] ADDR_KEY_SCAN = 4'h0;
    localparam logic [3:0] ADDR_KEY_SENSE = 4'h4;
    localparam logic [3:0] ADDR_PTR_CTRL = 4'h8;
    localparam logic [3:0] ADDR_PIN_MODE = 4'hc;
    localparam logic [7:0] KEY_SCAN_RESET = 8'hff;
    localparam logic [7:0] PIN_MODE_RESET = 8'h26;
    localparam logic [7:0] PIN_MODE_MASK = 8'h3f;
    localparam logic [7:0] PTR_CTRL_MASK = 8'hfb;
    localparam int PM_FIRST_SENSE_IN = 0;
    localparam int PM_KEY_SCAN_OUT = 1;
    localparam int PM_INDICATOR_OUT = 2;
    localparam int PM_WAKE_EN = 3;
    localparam int PM_SENSE_PD = 4;
    localparam int PM_KEY_IN_PD = 5;
    localparam int PC_RETAIN = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] scan_latch;
        logic [7:0] pin_mode;
        logic [7:0] ptr_ctrl;
        logic [7:0] scan_meta;
        logic [7:0] scan_sync;
        logic [3:0] key_meta;
        logic [3:0] key_sync;
        logic [2:0] sense_meta;
        logic [2:0] sense_sync;
        logic aw_seen;
        logic [3:0] aw_addr;
        logic w_seen;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic stop_release;
    } state_t;
endpackage

// >>> tb/key_matrix_model.sv
// Purpose: key matrix and indicator lamp facing the port pins
// Assumes: pressed keys pull a line high, open lines float
// Notes: floating lines toggle each cycle, so only a pull-down reads 0
`timescale 1ns/100ps
module key_matrix_model
(
    input wire logic aclk,
    input wire logic [7:0] press,
    input wire logic led_ext,
    input wire logic [7:0] key_scan_pins_out,
    input wire logic [7:0] key_scan_pins_oe_n,
    input wire logic key_scan_pulldown,
    input wire logic indicator_sense_pin_out,
    input wire logic indicator_sense_pin_oe_n,
    input wire logic indicator_sense_pulldown,
    output logic [7:0] key_scan_pins_in,
    output logic indicator_sense_pin_in
);
    logic tgl = 1'b0;
    // Floating level changes every cycle
    always @(posedge aclk)
        tgl <= ~tgl;
    // Wire level from driver, key and pull-down
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            key_scan_pins_in[i] = !key_scan_pins_oe_n[i] ? key_scan_pins_out[i] :
                (press[i] | (!key_scan_pulldown & tgl));
        indicator_sense_pin_in = !indicator_sense_pin_oe_n ? indicator_sense_pin_out :
            (led_ext | (!indicator_sense_pulldown & tgl));
    end
endmodule

// >>> tb/tb.sv
// Purpose: self-checking bench for the port register block
// Assumes: AXI4-Lite master in the bench, one access at a time
// Notes: reads note expectations in a queue, a monitor compares
`timescale 1ns/100ps
module tb;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, key_input_pins = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, first_sense_pin = 1'b0, indicator_drive = 1'b1, wake_sense_pin = 1'b0;
    logic release_condition = 1'b0, retention_detect_level = 1'b1, led_ext = 1'b0;
    logic [7:0] press = 8'h0, key_scan_pins_in, key_scan_pins_out, key_scan_pins_oe_n;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic key_scan_pulldown, key_input_pulldown, first_sense_enable, first_sense_pulldown;
    logic indicator_sense_pin_in, indicator_sense_pin_out, indicator_sense_pin_oe_n;
    logic indicator_sense_pulldown, wake_sense_pulldown, stop_release;
    logic [33:0] exp_q[$];
    integer seed = 80;
    int err_total = 0, checks = 0;

    always #20 aclk = ~aclk;

    key_scan_port_registers u_key_scan_port_registers (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .key_scan_pins_in, .key_scan_pins_out,
        .key_scan_pins_oe_n, .key_scan_pulldown, .key_input_pins, .key_input_pulldown, .first_sense_pin,
        .first_sense_enable, .first_sense_pulldown, .indicator_sense_pin_in, .indicator_sense_pin_out,
        .indicator_sense_pin_oe_n, .indicator_sense_pulldown, .indicator_drive, .wake_sense_pin,
        .wake_sense_pulldown, .release_condition, .stop_release, .retention_detect_level);
    key_matrix_model u_key_matrix_model (.aclk, .press, .led_ext, .key_scan_pins_out,
        .key_scan_pins_oe_n, .key_scan_pulldown, .indicator_sense_pin_out, .indicator_sense_pin_oe_n,
        .indicator_sense_pulldown, .key_scan_pins_in, .indicator_sense_pin_in);

    task chk(input string nm, input logic [33:0] s, input logic [33:0] e);
        checks++;
        if (s !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Reset with a chosen supply detector level
    task rst(input logic lvl);
        @(posedge aclk);
        retention_detect_level <= lvl;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        retention_detect_level <= 1'b0;
    endtask

    // Write: address and data offered together, released when taken
    task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk("bresp", 34'(s_axi_bresp), 34'(r));
        s_axi_bready <= 1'b0;
    endtask

    // Read: expectation queued, monitor compares the answer
    task rd(input logic [31:0] a, input logic [1:0] r, input logic [31:0] d);
        @(posedge aclk);
        exp_q.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    // Pin controls expected from a pin-mode value
    task pins(input logic [7:0] m);
        @(posedge aclk);
        chk("pins", 34'({key_scan_pins_oe_n, key_scan_pulldown, key_input_pulldown, first_sense_enable,
            first_sense_pulldown, indicator_sense_pin_oe_n, indicator_sense_pulldown, wake_sense_pulldown}),
            34'({{8{~m[1]}}, ~m[1], m[5], m[0], m[4] & m[0], ~m[2], m[4] & ~m[2], m[3]}));
    endtask

    // Answers come back in request order
    always @(posedge aclk)
        if (s_axi_rvalid && s_axi_rready)
            chk("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());

    // Bound well above the hundred or so cycles the tests need
    initial
    begin
        repeat (5000) @(posedge aclk);
        err_total++;
        finish_test();
    end

    initial
    begin
        rst(1'b1);
        rd(32'h0, 2'h0, 32'(port_pkg::KEY_SCAN_RESET));
        rd(32'hc, 2'h0, 32'(port_pkg::PIN_MODE_RESET));
        rd(32'h8, 2'h0, 32'h0);
        pins(8'h26);
        wr(32'h8, 32'hff, 2'h0);
        rd(32'h8, 2'h0, 32'hfb);
        rst(1'b0);
        rd(32'h8, 2'h0, 32'h08);
        $display("test reset done");
        wr(32'h0, 32'h5a, 2'h0);
        chk("latch", 34'(key_scan_pins_out), 34'h5a);
        rd(32'h0, 2'h0, 32'h5a);
        wr(32'hc, 32'h24, 2'h0);
        pins(8'h24);
        press <= 8'($random(seed));
        repeat (4) @(posedge aclk);
        rd(32'h0, 2'h0, 32'(press));
        wr(32'h0, 32'ha5, 2'h0);
        wr(32'hc, 32'h26, 2'h0);
        rd(32'h0, 2'h0, 32'ha5);
        $display("test key scan done");
        key_input_pins <= 4'($random(seed));
        indicator_drive <= 1'($random(seed));
        wake_sense_pin <= 1'b1;
        first_sense_pin <= 1'b0;
        repeat (4) @(posedge aclk);
        chk("led", 34'(indicator_sense_pin_out), 34'(indicator_drive));
        wr(32'h4, 32'h0, 2'h0);
        rd(32'h4, 2'h0, {24'h0, key_input_pins, indicator_drive, 3'h7});
        wr(32'hc, 32'h31, 2'h0);
        pins(8'h31);
        repeat (4) @(posedge aclk);
        rd(32'h4, 2'h0, {24'h0, key_input_pins, 4'h3});
        wr(32'hc, 32'h16, 2'h0);
        pins(8'h16);
        $display("test input port done");
        wr(32'hc, 32'h08, 2'h0);
        pins(8'h08);
        release_condition <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("stop", 34'(stop_release), 34'h1);
        wr(32'hc, 32'h00, 2'h0);
        repeat (3) @(posedge aclk);
        chk("stop", 34'(stop_release), 34'h0);
        wr(32'hc, 32'hff, 2'h0);
        rd(32'hc, 2'h0, 32'(port_pkg::PIN_MODE_MASK));
        wr(32'h10, 32'h0, port_pkg::RESP_SLVERR);
        rd(32'h10, port_pkg::RESP_SLVERR, 32'h0);
        $display("test modes done");
        repeat (2) @(posedge aclk);
        finish_test();
    end
endmodule
